// ### logic/wpcs_pkg.sv
package wpcs_pkg;

    // two-wire addressing of the protection register
    localparam logic [3:0] DEV_TYPE      = 4'hA;    // device type nibble
    localparam logic [1:0] CSR_SEL       = 2'h2;    // selector bits after the a0 bit
    localparam logic [7:0] CSR_ADDR      = 8'hFF;   // address byte of the register

    // data patterns and bit positions of protection_control_status
    localparam logic [7:0] WEL_SET       = 8'h02;
    localparam logic [7:0] WEL_CLR       = 8'h00;
    localparam int         BIT_WEL       = 1;
    localparam int         BIT_REGISTER_WRITE_ENABLE_LATCH      = 2;
    localparam int         BIT_LOCK_LO   = 3;
    localparam int         BIT_LOCK_HI   = 4;

    // region lock codes and the first locked address of each
    localparam logic [1:0] LOCK_NONE     = 2'h0;
    localparam logic [1:0] LOCK_QTR      = 2'h1;
    localparam logic [1:0] LOCK_HALF     = 2'h2;
    localparam logic [7:0] QTR_BASE      = 8'hC0;
    localparam logic [7:0] HALF_BASE     = 8'h80;
    localparam logic [1:0] LOCK_RESET    = 2'h0;    // copy value until the cell is read

    // timing
    localparam int         REF_PERIOD_NS = 25;
    localparam int         NV_CYCLE_NS   = 5000000; // nonvolatile store time
    localparam int         NV_CYCLES_DEF = NV_CYCLE_NS / REF_PERIOD_NS;
    localparam int         NV_CNT_W      = 18;
    localparam logic [1:0] START_GUARD   = 2'h3;    // cycles that mask stale byte events

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_DEV    = 3'h1,
        ST_REG    = 3'h2,
        ST_DATA   = 3'h3,
        ST_READ   = 3'h4,
        ST_IGNORE = 3'h5,
        ST_BUSY   = 3'h6
    } wpcs_state_e;

    typedef struct packed {
        wpcs_state_e         st;
        logic                global_write_enable_latch;
        logic                register_write_enable_latch;
        logic [1:0]          lock;
        logic                loaded;
        logic [2:0]          scl_s;
        logic [2:0]          sda_s;
        logic [2:0]          tgl_s;
        logic [1:0]          wp_s;
        logic [1:0]          a0_s;
        logic [1:0]          guard;
        logic                clr;
        logic                sda_oe;
        logic                ack_pend;
        logic                ack_drv;
        logic                got;
        logic                data_ok;
        logic                rd_act;
        logic [2:0]          rd_cnt;
        logic [7:0]          data;
        logic [NV_CNT_W-1:0] nv_cnt;
        logic                nv_stb;
    } wpcs_core_s;

    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rx;
        logic       tgl;
    } wpcs_link_s;

    // true when an array address falls inside the locked region
    function automatic logic ee_locked(input logic [7:0] addr, input logic [1:0] lock);
        case (lock)
            LOCK_NONE: ee_locked = 1'b0;
            LOCK_QTR:  ee_locked = (addr >= QTR_BASE);
            LOCK_HALF: ee_locked = (addr >= HALF_BASE);
            default:   ee_locked = 1'b1;
        endcase
    endfunction : ee_locked

endpackage : wpcs_pkg

// ### logic/wpcs_link_if.sv
interface wpcs_link_if;
    logic       clr;     // core to link: clears the bit engine at a start
    logic       tgl;     // link to core: toggles once per received byte
    logic [7:0] rx_byte; // link to core: last byte, stable until the next toggle

    modport link (input clr, output tgl, output rx_byte);
    modport core (output clr, input tgl, input rx_byte);
endinterface : wpcs_link_if

// ### logic/wpcs_link.sv
module wpcs_link
    import wpcs_pkg::*;
#(
    parameter int BITS = 8
) (
    input wire logic  scl_clk, // bus clock from the master
    input wire logic  sda_in,  // bus data level
    wpcs_link_if.link lnk      // byte path to the core
);

    wpcs_link_s q;
    wpcs_link_s n;

    if (BITS != 8) begin : g_chk
        $error("wpcs_link serves 8-bit bytes only");
    end

    // shift on rising scl, nine clocks per byte including the acknowledge slot
    always_comb begin
        n    = q;
        n.sh = {q.sh[6:0], sda_in};
        if (q.cnt == 4'h8) begin
            n.cnt = 4'h0;
        end else begin
            n.cnt = q.cnt + 4'h1;
        end
        if (q.cnt == 4'h7) begin
            n.rx  = {q.sh[6:0], sda_in};
            n.tgl = ~q.tgl;
        end
    end

    // clear is a core flop released while scl stands high after a start
    always_ff @(posedge scl_clk or posedge lnk.clr) begin
        if (lnk.clr) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign lnk.tgl     = q.tgl;
    assign lnk.rx_byte = q.rx;

endmodule : wpcs_link

// ### logic/wpcs_top.sv
// Function
// - Power-up clears both volatile latches; lock bits come back from the cell.
// - With write enable clear, writes other than 02h abort and the data byte is not acknowledged.
// - Writing 02h sets write enable, 00h clears it; any accepted write copies bit 1 into it.
// - A latch-only register write starts no store; next operation right after stop.
// - Register write enable starts at 0 and gates any change to lock bits.
// - Register write enable is set only while write enable is already set.
// - Register write enable clears after a register write with bit 2 clear or a locked-region attempt.
// - Lock code selects protected array range: none, C0h-FFh, 80h-FFh, all.
// - Array writes into a locked range are refused, contents untouched.
// - Any nonzero lock code refuses every potentiometer write.
// - Shipped lock bits are both zero, nothing locked.
// - Write-protect pin high blocks all nonvolatile array and potentiometer writes.
// - One data byte per register write; a second is not acknowledged, write aborted.
// - Reserved bits 7..5 and 0 are written zero and always read zero.
// - Steps 02h then 06h are volatile, accepted without delay.
// - Third step 000st010 clears register enable and stores lock bits in a 5 ms cycle.
// - Bit 2 set in third step sets register enable, lock bits unchanged.
// - Write-protect pin high ignores nonvolatile bit writes; latches stay writable.
// - Read: pointer FFh, then read direction; one byte, then access ends.
// - Reading the register leaves the latches and a pending sequence untouched.
// - During a store cycle bus requests are ignored and data stays released.
// - Array write into a locked range gets no address acknowledge.
module wpcs_top
    import wpcs_pkg::*;
#(
    parameter int NV_CYCLES = NV_CYCLES_DEF
) (
    input  wire logic       ref_clk,         // core clock, 40 MHz
    input  wire logic       rst,             // asynchronous reset, power-up
    input  wire logic       scl_clk,         // bus clock from the master
    input  wire logic       sda_in,          // bus data level
    output logic            sda_out,         // open-drain data, always low when enabled
    output logic            sda_oe,          // high while pulling data low
    input  wire logic       wp_pin,          // write-protect pin
    input  wire logic       a0_pin,          // device address pin
    input  wire logic [1:0] nv_lock_restore, // lock bits held in the nonvolatile cell
    output logic            nv_store_stb,    // one-cycle strobe: program the cell
    output logic [1:0]      nv_store_lock,   // lock bits to program
    output logic            nv_busy,         // nonvolatile cycle in progress
    input  wire logic       ee_wr_req,       // array sequencer: write attempt pulse
    input  wire logic [7:0] ee_wr_addr,      // array address of the attempt
    output logic            ee_wr_grant,     // array write allowed at ee_wr_addr
    input  wire logic       dcp_wr_nv,       // potentiometer query is nonvolatile
    output logic            dcp_wr_grant,    // potentiometer write allowed
    output logic            global_write_enable_latch,             // global_write_enable_latch
    output logic            register_write_enable_latch,            // register_write_enable_latch
    output logic [1:0]      lock             // {region_lock_hi, region_lock_lo}
);

    wpcs_core_s  q;
    wpcs_core_s  n;
    wpcs_link_if lnk ();

    logic       scl_now;
    logic       scl_old;
    logic       sda_now;
    logic       sda_old;
    logic       wp;
    logic       start;
    logic       stop;
    logic       scl_fall;
    logic       byte_ev;
    logic [7:0] rx;
    logic [7:0] status;
    logic       commit;

    if (NV_CYCLES < 1 || NV_CYCLES >= 2 ** NV_CNT_W) begin : g_chk
        $error("NV_CYCLES does not fit the store counter");
    end

    wpcs_link #(
        .BITS (8)
    ) u_link (
        .scl_clk (scl_clk),
        .sda_in  (sda_in),
        .lnk     (lnk)
    );

    // synchronised pins and the conditions derived from them
    assign scl_now  = q.scl_s[1];
    assign scl_old  = q.scl_s[2];
    assign sda_now  = q.sda_s[1];
    assign sda_old  = q.sda_s[2];
    assign wp       = q.wp_s[1];
    assign start    = scl_now && scl_old && sda_old && !sda_now;
    assign stop     = scl_now && scl_old && !sda_old && sda_now;
    assign scl_fall = scl_old && !scl_now;
    assign byte_ev  = (q.tgl_s[1] ^ q.tgl_s[2]) && (q.guard == 2'h0);
    assign rx       = lnk.rx_byte;

    // register image; reserved positions stay zero
    always_comb begin
        status                           = '0;
        status[BIT_WEL]                  = q.global_write_enable_latch;
        status[BIT_REGISTER_WRITE_ENABLE_LATCH]                 = q.register_write_enable_latch;
        status[BIT_LOCK_HI:BIT_LOCK_LO]  = q.lock;
    end

    // next-state of the whole core
    always_comb begin
        n        = q;
        commit   = 1'b0;
        n.scl_s  = {q.scl_s[1:0], scl_clk};
        n.sda_s  = {q.sda_s[1:0], sda_in};
        n.tgl_s  = {q.tgl_s[1:0], lnk.tgl};
        n.wp_s   = {q.wp_s[0], wp_pin};
        n.a0_s   = {q.a0_s[0], a0_pin};
        n.clr    = 1'b0;
        n.nv_stb = 1'b0;
        if (q.guard != 2'h0) begin
            n.guard = q.guard - 2'h1;
        end
        if (!q.loaded) begin
            n.loaded = 1'b1;
            n.lock   = nv_lock_restore;
        end
        if (q.st == ST_BUSY) begin
            n.sda_oe = 1'b0;
            if (q.nv_cnt == '0) begin
                n.st   = ST_IDLE;
                n.register_write_enable_latch = 1'b0;
            end else begin
                n.nv_cnt = q.nv_cnt - NV_CNT_W'(1);
            end
        end else if (start) begin
            n.st       = ST_DEV;
            n.clr      = 1'b1;
            n.guard    = START_GUARD;
            n.sda_oe   = 1'b0;
            n.ack_pend = 1'b0;
            n.ack_drv  = 1'b0;
            n.rd_act   = 1'b0;
            n.got      = 1'b0;
            n.data_ok  = 1'b0;
        end else if (stop) begin
            n.st       = ST_IDLE;
            n.sda_oe   = 1'b0;
            n.ack_pend = 1'b0;
            n.ack_drv  = 1'b0;
            n.rd_act   = 1'b0;
            if (q.st == ST_DATA && q.data_ok) begin
                commit = 1'b1;
                n.global_write_enable_latch  = q.data[BIT_WEL];
                if (q.data[BIT_REGISTER_WRITE_ENABLE_LATCH] && q.global_write_enable_latch) begin
                    n.register_write_enable_latch = 1'b1;
                end else if (q.register_write_enable_latch) begin
                    n.register_write_enable_latch = 1'b0;
                    if (q.data[BIT_WEL] && !wp) begin
                        n.lock   = q.data[BIT_LOCK_HI:BIT_LOCK_LO];
                        n.nv_stb = 1'b1;
                        n.st     = ST_BUSY;
                        n.nv_cnt = NV_CNT_W'(NV_CYCLES - 1);
                    end
                end
            end
        end else begin
            // byte complete: decide the acknowledge
            if (byte_ev) begin
                case (q.st)
                    ST_DEV: begin
                        if (rx[7:1] == {DEV_TYPE, q.a0_s[1], CSR_SEL}) begin
                            n.ack_pend = 1'b1;
                            n.data     = status;
                            n.st       = rx[0] ? ST_READ : ST_REG;
                        end else begin
                            n.st = ST_IGNORE;
                        end
                    end
                    ST_REG: begin
                        if (rx == CSR_ADDR) begin
                            n.ack_pend = 1'b1;
                            n.st       = ST_DATA;
                        end else begin
                            n.st = ST_IGNORE;
                        end
                    end
                    ST_DATA: begin
                        if (!q.got && (q.global_write_enable_latch || rx == WEL_SET)) begin
                            n.ack_pend = 1'b1;
                            n.got      = 1'b1;
                            n.data     = rx;
                        end else begin
                            n.st = ST_IGNORE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // falling scl: drive or release the data line
            if (scl_fall) begin
                if (q.ack_pend) begin
                    n.sda_oe   = 1'b1;
                    n.ack_pend = 1'b0;
                    n.ack_drv  = 1'b1;
                end else if (q.ack_drv) begin
                    n.ack_drv = 1'b0;
                    n.sda_oe  = 1'b0;
                    if (q.st == ST_READ) begin
                        n.rd_act = 1'b1;
                        n.rd_cnt = 3'h7;
                        n.sda_oe = ~q.data[7];
                    end
                    if (q.st == ST_DATA && q.got) begin
                        n.data_ok = 1'b1;
                    end
                end else if (q.rd_act) begin
                    if (q.rd_cnt == 3'h0) begin
                        n.sda_oe = 1'b0;
                        n.rd_act = 1'b0;
                        n.st     = ST_IGNORE;
                    end else begin
                        n.rd_cnt = q.rd_cnt - 3'h1;
                        n.sda_oe = ~q.data[q.rd_cnt - 3'h1];
                    end
                end
            end
        end
        // attempt into a locked array range drops register enable
        if (ee_wr_req && ee_locked(ee_wr_addr, q.lock)) begin
            n.register_write_enable_latch = 1'b0;
        end
    end

    // core state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q        <= '0;
            q.st     <= ST_IDLE;
            q.lock   <= LOCK_RESET;
            q.clr    <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // outputs
    assign lnk.clr       = q.clr;
    assign sda_out       = 1'b0;
    assign sda_oe        = q.sda_oe;
    assign nv_store_stb  = q.nv_stb;
    assign nv_store_lock = q.lock;
    assign nv_busy       = (q.st == ST_BUSY);
    assign global_write_enable_latch           = q.global_write_enable_latch;
    assign register_write_enable_latch          = q.register_write_enable_latch;
    assign lock          = q.lock;

    // permission queries from the array and potentiometer sequencers
    assign ee_wr_grant  = q.global_write_enable_latch && !wp && !ee_locked(ee_wr_addr, q.lock)
                          && (q.st != ST_BUSY);
    assign dcp_wr_grant = q.global_write_enable_latch && (q.lock == LOCK_NONE) && !(dcp_wr_nv && wp)
                          && (q.st != ST_BUSY);

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence commit_s;
        commit;
    endsequence
    sequence data_byte_s;
        byte_ev && (q.st == ST_DATA);
    endsequence
    sequence locked_try_s;
        ee_wr_req && ee_locked(ee_wr_addr, q.lock);
    endsequence

    wel_set_a: assert property (commit_s and (q.data == WEL_SET) |=> q.global_write_enable_latch)
        else $error("write enable not set by 02h");
    wel_clear_a: assert property (commit_s and (q.data == WEL_CLR) |=> !q.global_write_enable_latch && !q.register_write_enable_latch)
        else $error("write enable not cleared by 00h");
    wel_hold_a: assert property (q.global_write_enable_latch && !commit |=> q.global_write_enable_latch)
        else $error("write enable dropped without a write");
    register_write_enable_latch_needs_wel_a: assert property ($rose(q.register_write_enable_latch) |-> $past(q.global_write_enable_latch))
        else $error("register enable set without write enable");
    nack_gate_a: assert property (data_byte_s and (!q.global_write_enable_latch && rx != WEL_SET)
                                  |=> !q.ack_pend ##1 !q.ack_pend)
        else $error("data byte acknowledged with write enable clear");
    extra_byte_a: assert property (data_byte_s and q.got |=> q.st == ST_IGNORE)
        else $error("second data byte not aborted");
    store_start_a: assert property (q.nv_stb |-> !$past(q.wp_s[1]) and nv_busy [*8])
        else $error("store cycle not held busy");
    store_end_a: assert property ($fell(nv_busy) |-> !q.register_write_enable_latch && !q.sda_oe)
        else $error("register enable left set after store");
    busy_quiet_a: assert property (nv_busy |-> !sda_oe)
        else $error("data driven during store cycle");
    wp_lock_a: assert property (q.loaded && q.wp_s[1] |=> $stable(q.lock))
        else $error("lock bits changed while write-protected");
    dcp_lock_a: assert property (q.lock != LOCK_NONE |-> !dcp_wr_grant)
        else $error("potentiometer write granted while locked");
    ee_grant_a: assert property (ee_wr_grant |-> !wp && q.global_write_enable_latch
                                 && !ee_locked(ee_wr_addr, q.lock))
        else $error("array write granted into protection");
    locked_try_a: assert property (locked_try_s |=> !q.register_write_enable_latch)
        else $error("register enable kept after locked attempt");
    read_keep_a: assert property ((q.st == ST_READ) && !ee_wr_req
                                  |=> $stable(q.global_write_enable_latch) && $stable(q.register_write_enable_latch))
        else $error("register read disturbed the latches");

endmodule : wpcs_top

// ### verification/wpcs_bus_master.sv
// two-wire bus master: scl stands high between frames, data is open drain
module wpcs_bus_master (
    output logic     scl,     // bus clock
    output logic     sda_drv, // master data level, 1 releases
    input wire logic sda_line // resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int H = 600; // half bit, keeps scl high and low >= 0.6 us
    localparam int Q = 300;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // start: data falls while the clock is high
    task automatic bus_start();
        sda_drv = 1'b0;
        #H scl = 1'b0;
    endtask : bus_start

    // repeated start from a low clock
    task automatic bus_rstart();
        #Q sda_drv = 1'b1;
        #Q scl = 1'b1;
        #H sda_drv = 1'b0;
        #H scl = 1'b0;
    endtask : bus_rstart

    // stop: data rises while the clock is high, clock then stands still
    task automatic bus_stop();
        #Q sda_drv = 1'b0;
        #Q scl = 1'b1;
        #H sda_drv = 1'b1;
        #H;
    endtask : bus_stop

    // data moves mid low phase, sampled late in the high phase
    task automatic bus_bit(input logic b, output logic s);
        #Q sda_drv = b;
        #Q scl = 1'b1;
        #H s = sda_line;
        scl = 1'b0;
    endtask : bus_bit

    // msb first; a full byte takes the acknowledge on the ninth clock
    task automatic bus_byte(input logic [7:0] d, input int nbits, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) bus_bit(d[i], s);
        if (nbits == 8) begin
            bus_bit(1'b1, s);
            ack = ~s;
        end
    endtask : bus_byte

    // one byte in, then no acknowledge so the device lets go
    task automatic bus_read(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, s);
            d[i] = s;
        end
        bus_bit(1'b1, s);
    endtask : bus_read
endmodule : wpcs_bus_master

// ### verification/wpcs_top_tb_top.sv
module wpcs_top_tb_top
    import wpcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NVC = 64; // shortened store cycle
    logic       ref_clk, rst, scl, sda_drv, sda_out, sda_oe, wp_pin, a0_pin;
    logic       nv_store_stb, nv_busy, ee_wr_req, ee_wr_grant, dcp_wr_nv;
    logic       dcp_wr_grant, global_write_enable_latch, register_write_enable_latch;
    logic [1:0] nv_lock_restore, nv_store_lock, lock;
    logic [7:0] ee_wr_addr;
    logic [7:0] bad [3] = '{8'h00, 8'h06, 8'h1A};
    logic [7:0] adrs [6] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
    wire        sda_line;
    int         fails, n_compared, n_stores, m_wel, m_register_write_enable_latch, m_lock, m_busy, m_stores;

    // open-drain line with pull-up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    wpcs_top #(.NV_CYCLES(NVC)) DUT (
        .ref_clk(ref_clk), .rst(rst), .scl_clk(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp_pin), .a0_pin(a0_pin),
        .nv_lock_restore(nv_lock_restore), .nv_store_stb(nv_store_stb),
        .nv_store_lock(nv_store_lock), .nv_busy(nv_busy), .ee_wr_req(ee_wr_req),
        .ee_wr_addr(ee_wr_addr), .ee_wr_grant(ee_wr_grant), .dcp_wr_nv(dcp_wr_nv),
        .dcp_wr_grant(dcp_wr_grant), .global_write_enable_latch(global_write_enable_latch), .register_write_enable_latch(register_write_enable_latch), .lock(lock));
    wpcs_bus_master BM (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // nonvolatile cell: keeps the lock bits of each store strobe
    always @(posedge ref_clk) begin
        if (nv_store_stb === 1'b1) begin
            nv_lock_restore <= nv_store_lock;
            n_stores++;
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic state_chk();
        check("wel", {7'h00, global_write_enable_latch}, 8'(m_wel));
        check("register_write_enable_latch", {7'h00, register_write_enable_latch}, 8'(m_register_write_enable_latch));
        check("lock", {6'h00, lock}, 8'(m_lock));
        check("cell", {6'h00, nv_lock_restore}, 8'(m_lock));
        check("busy", {7'h00, nv_busy}, 8'(m_busy));
        check("stores", 8'(n_stores), 8'(m_stores));
    endtask : state_chk

    // reference of one accepted register byte
    task automatic commit(input logic [7:0] d);
        int ow;
        ow = m_wel;
        m_wel = d[1];
        if (d[2] && ow) m_register_write_enable_latch = 1;
        else if (m_register_write_enable_latch) begin
            m_register_write_enable_latch = 0;
            if (d[1] && !wp_pin) begin
                m_lock = d[4:3];
                m_stores++;
                m_busy = 1;
            end
        end
    endtask : commit

    task automatic reg_write(input logic [7:0] d, input int nbits = 8, input bit extra = 1'b0);
        logic a;
        bit   take;
        take = nbits == 8 && (m_wel || d == WEL_SET);
        @(negedge ref_clk);
        BM.bus_start();
        BM.bus_byte({DEV_TYPE, a0_pin, CSR_SEL, 1'b0}, 8, a);
        check("dev ack", {7'h00, a}, 8'h01);
        BM.bus_byte(CSR_ADDR, 8, a);
        BM.bus_byte(d, nbits, a);
        if (nbits == 8) check("data ack", {7'h00, a}, 8'(take));
        if (extra) begin
            BM.bus_byte(8'h00, 8, a);
            check("extra ack", {7'h00, a}, 8'h00);
        end
        BM.bus_stop();
        if (take && !extra) commit(d);
        state_chk();
    endtask : reg_write

    task automatic reg_read();
        logic       a;
        logic [7:0] d;
        @(negedge ref_clk);
        BM.bus_start();
        BM.bus_byte({DEV_TYPE, a0_pin, CSR_SEL, 1'b0}, 8, a);
        BM.bus_byte(CSR_ADDR, 8, a);
        BM.bus_rstart();
        BM.bus_byte({DEV_TYPE, a0_pin, CSR_SEL, 1'b1}, 8, a);
        BM.bus_read(d);
        BM.bus_stop();
        check("reg read", d, 8'((m_lock << 3) | (m_register_write_enable_latch << 2) | (m_wel << 1)));
        state_chk();
    endtask : reg_read

    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && nv_busy !== 1'b0; n++) @(negedge ref_clk);
        if (n == 1000) begin
            fails++;
            report_and_stop();
        end else begin
            m_busy = 0;
        end
    endtask : wait_idle

    task automatic set_lock(input logic [1:0] st);
        reg_write(WEL_SET);
        reg_write(8'h06);
        reg_read();
        reg_write({3'b000, st, 3'b010});
        wait_idle();
    endtask : set_lock

    // array and potentiometer permission at one address
    task automatic probe(input logic [7:0] adr);
        bit lk;
        @(negedge ref_clk);
        ee_wr_addr = adr;
        dcp_wr_nv = 1'($urandom());
        lk = m_lock == 3 || (m_lock == 2 && adr >= 8'h80) || (m_lock == 1 && adr >= 8'hC0);
        #1;
        check("ee grant", {7'h00, ee_wr_grant}, 8'(m_wel && !wp_pin && !lk));
        check("dcp grant", {7'h00, dcp_wr_grant},
              8'(m_wel && m_lock == 0 && !(dcp_wr_nv && wp_pin)));
        if (!wp_pin) begin
            @(negedge ref_clk) ee_wr_req = 1'b1;
            @(negedge ref_clk) ee_wr_req = 1'b0;
            if (lk) m_register_write_enable_latch = 0;
            @(negedge ref_clk);
            check("register_write_enable_latch", {7'h00, register_write_enable_latch}, 8'(m_register_write_enable_latch));
        end
    endtask : probe

    task automatic power_up();
        @(negedge ref_clk) rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        m_wel = 0;
        m_register_write_enable_latch = 0;
        repeat (4) @(negedge ref_clk);
        state_chk();
    endtask : power_up

    initial begin
        logic a;
        {rst, wp_pin, ee_wr_req, dcp_wr_nv} = 4'h8; // reset held from time zero
        ee_wr_addr = 8'h00;
        nv_lock_restore = 2'b00; // factory: nothing locked
        {fails, n_compared, n_stores, m_wel, m_register_write_enable_latch, m_lock, m_busy, m_stores} = '0;
        void'($urandom(32'h3b7a_6c4b));
        a0_pin = 1'($urandom());
        power_up();
        reg_read();
        foreach (bad[i]) reg_write(bad[i]);
        reg_write(WEL_SET);
        reg_read();
        reg_write(WEL_CLR);
        reg_write(WEL_SET);
        reg_write(WEL_CLR, 8, 1'b1);
        reg_write(WEL_CLR, 4);
        reg_write(8'h06);
        reg_write(8'h1E);
        reg_write(8'h1A);
        @(negedge ref_clk);
        BM.bus_start();
        BM.bus_byte({DEV_TYPE, a0_pin, CSR_SEL, 1'b0}, 8, a);
        check("busy ack", {7'h00, a}, 8'h00);
        BM.bus_stop();
        wait_idle();
        // foreign device address, then a wrong address byte: both refused
        @(negedge ref_clk);
        BM.bus_start();
        BM.bus_byte({DEV_TYPE, ~a0_pin, CSR_SEL, 1'b0}, 8, a);
        check("other dev ack", {7'h00, a}, 8'h00);
        BM.bus_stop();
        @(negedge ref_clk);
        BM.bus_start();
        BM.bus_byte({DEV_TYPE, a0_pin, CSR_SEL, 1'b0}, 8, a);
        BM.bus_byte(8'h7F, 8, a);
        check("addr ack", {7'h00, a}, 8'h00);
        BM.bus_stop();
        state_chk();
        for (int c = 3; c >= 0; c--) begin
            set_lock(2'(c));
            reg_write(8'h06);
            foreach (adrs[i]) probe(adrs[i]);
            repeat (4) probe(8'($urandom()));
        end
        @(negedge ref_clk) wp_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        repeat (4) probe(8'($urandom()));
        set_lock(2'b11);
        reg_write(WEL_CLR);
        @(negedge ref_clk) wp_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        set_lock(2'b01);
        power_up();
        report_and_stop();
    end
endmodule : wpcs_top_tb_top
